// ==== design/pmsp_pkg.sv ====
/*
  Package for the parallel master/slave port: register offsets, register
  layouts, reset values, state encodings and timing constants.
  Assumes a 25 MHz system clock that also serves as the bus clock.
*/
`default_nettype none
package pmsp_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_CONTROL = 8'h00;  // port_control
  localparam logic [7:0] OFS_MODE    = 8'h04;  // port_mode
  localparam logic [7:0] OFS_ADDR    = 8'h08;  // address counter
  localparam logic [7:0] OFS_DATA    = 8'h0C;  // master data, starts a transfer
  localparam logic [7:0] OFS_SLV_OUT = 8'h10;  // slave output buffers, 4 bytes
  localparam logic [7:0] OFS_SLV_IN  = 8'h14;  // slave input buffers, 4 bytes
  localparam logic [7:0] OFS_SLV_ST  = 8'h18;  // slave buffer flags

  // encodings
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ENH    = 2'h1;
  localparam logic [1:0] MODE_M2     = 2'h2;
  localparam logic [1:0] MODE_M1     = 2'h3;
  localparam logic [1:0] MUX_NONE    = 2'h0;
  localparam logic [1:0] MUX_LOW_UP  = 2'h1;
  localparam logic [1:0] MUX_FULL    = 2'h2;
  localparam logic [1:0] MUX_LOW     = 2'h3;
  localparam logic [1:0] CS_FUNC_SEL = 2'h2;
  localparam logic [1:0] IRQ_CYCLE   = 2'h1;
  localparam logic [1:0] IRQ_BUF3    = 2'h2;
  localparam logic [1:0] STEP_INC    = 2'h1;
  localparam logic [1:0] STEP_DEC    = 2'h2;
  localparam logic [1:0] STEP_BUF    = 2'h3;
  localparam logic [1:0] BUF_LAST    = 2'h3;
  localparam logic [3:0] WAIT_MIN    = 4'h0;

  // timing: one bus clock period is one system clock cycle
  localparam int BUS_CLOCK_PERIOD_NS = 40;
  localparam int CLK_SYS_PERIOD_NS   = 40;
  localparam int CYC_PER_BUS_CLOCK   = BUS_CLOCK_PERIOD_NS / CLK_SYS_PERIOD_NS;

  // control register layout, low 16 bits
  typedef struct packed {
    logic       enable;               // 15
    logic       rsv14;
    logic       stop_in_idle;         // 13
    logic [1:0] addr_data_mux_sel;    // 12:11
    logic       input_buffer_sel;     // 10
    logic       wr_strobe_pin_en;     // 9
    logic       rd_strobe_pin_en;     // 8
    logic [1:0] chip_select_function; // 7:6
    logic       addr_latch_polarity;  // 5
    logic       rsv4;
    logic       chip_select_polarity; // 3
    logic       rsv2;
    logic       write_strobe_polarity;// 1
    logic       read_strobe_polarity; // 0
  } pmsp_control_s;

  // mode register layout, low 16 bits
  typedef struct packed {
    logic       busy;                 // 15, read only
    logic [1:0] irq_mode;             // 14:13
    logic [1:0] addr_step_mode;       // 12:11
    logic       rsv10;
    logic [1:0] port_mode_sel;        // 9:8
    logic [1:0] setup_wait;           // 7:6
    logic [3:0] strobe_wait;          // 5:2
    logic [1:0] hold_wait;            // 1:0
  } pmsp_mode_s;

  localparam logic [15:0] CONTROL_WMASK = 16'hBFEB;
  localparam logic [15:0] MODE_WMASK    = 16'h7BFF;
  localparam logic [15:0] RESET_16      = 16'h0000;

  typedef enum logic [2:0] {
    M_IDLE, M_ADDR_LO, M_ADDR_HI, M_SETUP, M_STROBE, M_HOLD
  } pmsp_mst_e;

endpackage : pmsp_pkg

`default_nettype wire

// ==== design/pmsp_port.sv ====
/*
  Parallel master/slave port: register file, master transfer engine and
  legacy/enhanced slave with four byte buffers in each direction.
  Assumes all pin inputs are synchronous to clk_sys and that the system
  clock is also the peripheral bus clock.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pmsp_port
  import pmsp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // system state
  input  wire logic        sys_idle,
  output var  logic        port_irq,
  // data pins
  input  wire logic [7:0]  port_data_pins_in,
  output var  logic [7:0]  port_data_pins_out,
  output var  logic        port_data_pins_oe,
  // address pins, bits 1:0 double as latch strobes or slave address
  input  wire logic [1:0]  port_addr_pins_in,
  output var  logic [10:0] port_addr_pins_out,
  output var  logic        port_addr_pins_oe,
  // chip select or address bit 14
  input  wire logic        chip_select_pin_in,
  output var  logic        chip_select_pin_out,
  output var  logic        chip_select_pin_oe,
  // read strobe or read/write strobe
  input  wire logic        read_strobe_pin_in,
  output var  logic        read_strobe_pin_out,
  output var  logic        read_strobe_pin_oe,
  // write strobe or enable strobe
  input  wire logic        write_strobe_pin_in,
  output var  logic        write_strobe_pin_out,
  output var  logic        write_strobe_pin_oe
);

  // all state of the block in one record
  typedef struct packed {
    pmsp_control_s ctl;        // port_control
    pmsp_mode_s    mde;        // port_mode, busy mirrors the engine
    logic [10:0]   addr_lo;    // address bits 10:0
    logic          addr_hi14;  // address bit 14 or chip-select bit
    logic [7:0]    tx_data;    // byte for master writes
    logic [7:0]    rx_data;    // byte caught by master reads
    pmsp_mst_e     mst;        // master engine phase
    logic [3:0]    cnt;        // phase cycles left minus one
    logic          is_read;    // current master transfer direction
    logic [31:0]   out_buf;    // slave output buffers, byte n = buffer n
    logic [31:0]   in_buf;     // slave input buffers
    logic [3:0]    in_full;    // host wrote buffer n
    logic [3:0]    out_empty;  // host read buffer n
    logic [1:0]    buf_ptr;    // legacy slave buffer pointer
    logic          prev_rd;    // host read strobe active last cycle
    logic          prev_wr;    // host write strobe active last cycle
    logic [1:0]    prev_idx;   // buffer selected last cycle
    logic [31:0]   rdata;      // register read data
    logic          irq;        // interrupt pulse
    logic [7:0]    d_out;      // pin drivers
    logic          d_oe;
    logic [10:0]   a_out;
    logic          a_oe;
    logic          cs_out;
    logic          cs_oe;
    logic          rd_out;
    logic          rd_oe;
    logic          wr_out;
    logic          wr_oe;
  } pmsp_state_s;

  pmsp_state_s state_reg;  // registered state
  pmsp_state_s state_next; // next state

  // derived controls
  logic       run;         // port enabled and not stopped by idle
  logic       is_master;   // master mode 1 or 2
  logic       cs_as_sel;   // chip-select pin works as a select
  logic       fast;        // strobe wait at its minimum
  logic [3:0] setup_len;   // setup and address phase cycles, minus one
  logic [2:0] hold_len;    // hold cycles, zero allowed on reads
  logic       h_cs;        // host select active
  logic       h_rd;        // host read strobe active
  logic       h_wr;        // host write strobe active
  logic [1:0] s_idx;       // slave buffer selected now
  logic [11:0] step_val;   // address with bit 14 as its top bit
  logic       lat_lo;      // low latch strobe wanted
  logic       lat_hi;      // high latch strobe wanted
  logic       strobe_on;   // master strobe phase
  logic       sw_rd_in;    // software reads the slave input buffers
  logic       sw_wr_out;   // software writes the slave output buffers

  // combinational controls shared by the main process
  always_comb begin
    run       = state_reg.ctl.enable & ~(state_reg.ctl.stop_in_idle & sys_idle);
    is_master = state_reg.mde.port_mode_sel[1];
    cs_as_sel = state_reg.ctl.chip_select_function == CS_FUNC_SEL;
    fast      = state_reg.mde.strobe_wait == WAIT_MIN;
    // zero strobe wait forces one setup cycle; hold one on writes, none on reads
    if (fast) begin
      setup_len = 4'h0;
      hold_len  = state_reg.is_read ? 3'h0 : 3'h1;
    end else begin
      setup_len = {2'h0, state_reg.mde.setup_wait};
      hold_len  = state_reg.is_read ? {1'b0, state_reg.mde.hold_wait}
                                    : {1'b0, state_reg.mde.hold_wait} + 3'h1;
    end
    // host strobes compared against the programmed active levels
    h_cs  = chip_select_pin_in == state_reg.ctl.chip_select_polarity;
    h_rd  = h_cs & (read_strobe_pin_in == state_reg.ctl.read_strobe_polarity);
    h_wr  = h_cs & (write_strobe_pin_in == state_reg.ctl.write_strobe_polarity);
    // enhanced slave decodes two address bits, legacy uses the pointer in buffer step mode, else buffer 0
    if (state_reg.mde.port_mode_sel == MODE_ENH) begin
      s_idx = port_addr_pins_in;
    end else if (state_reg.mde.addr_step_mode == STEP_BUF) begin
      s_idx = state_reg.buf_ptr;
    end else begin
      s_idx = 2'h0;
    end
    sw_rd_in  = reg_rd & (reg_addr == OFS_SLV_IN);
    sw_wr_out = reg_wr & (reg_addr == OFS_SLV_OUT);
  end

  // main next-state process: registers, master engine, slave, pins
  always_comb begin
    state_next     = state_reg;
    state_next.irq = 1'b0;
    lat_lo         = 1'b0;
    lat_hi         = 1'b0;
    strobe_on      = 1'b0;
    step_val       = {state_reg.addr_hi14, state_reg.addr_lo}; // address before any step

    // register writes; a write to data while busy updates the byte but starts no transfer
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CONTROL: state_next.ctl = pmsp_control_s'(reg_wdata[15:0] & CONTROL_WMASK);
        OFS_MODE: begin
          state_next.mde      = pmsp_mode_s'(reg_wdata[15:0] & MODE_WMASK);
          state_next.mde.busy = state_reg.mde.busy;
        end
        OFS_ADDR: begin
          state_next.addr_lo   = reg_wdata[10:0];
          state_next.addr_hi14 = reg_wdata[14];
        end
        OFS_DATA:    state_next.tx_data = reg_wdata[7:0];
        OFS_SLV_OUT: state_next.out_buf = reg_wdata;
        default: ;
      endcase
    end

    // register reads, data one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CONTROL: state_next.rdata = {16'h0000, state_reg.ctl};
        OFS_MODE:    state_next.rdata = {16'h0000, state_reg.mde};
        OFS_ADDR:    state_next.rdata = {17'h00000, state_reg.addr_hi14, 3'h0,
                                         state_reg.addr_lo};
        OFS_DATA:    state_next.rdata = {24'h000000, state_reg.rx_data};
        OFS_SLV_OUT: state_next.rdata = state_reg.out_buf;
        OFS_SLV_IN:  state_next.rdata = state_reg.in_buf;
        OFS_SLV_ST:  state_next.rdata = {16'h0000, 4'h0, state_reg.in_full,
                                         4'h0, state_reg.out_empty};
        default:     state_next.rdata = 32'h00000000;
      endcase
    end

    // software side of the slave flags; hardware sets below win
    if (sw_rd_in) begin
      state_next.in_full = 4'h0;
    end
    if (sw_wr_out) begin
      state_next.out_empty = 4'h0;
    end

    // master engine, frozen while not running
    if (run && is_master) begin
      unique case (state_reg.mst)
        M_IDLE: begin
          // a data write starts a write, a data read starts a read
          if ((reg_wr || reg_rd) && reg_addr == OFS_DATA) begin
            state_next.is_read  = reg_rd;
            state_next.mde.busy = 1'b1;
            state_next.cnt      = setup_len;
            state_next.mst = (state_reg.ctl.addr_data_mux_sel == MUX_NONE) ? M_SETUP
                                                                            : M_ADDR_LO;
          end
        end
        M_ADDR_LO: begin
          if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
          end else begin
            state_next.cnt = setup_len;
            state_next.mst = (state_reg.ctl.addr_data_mux_sel == MUX_FULL) ? M_ADDR_HI
                                                                            : M_SETUP;
          end
        end
        M_ADDR_HI: begin
          if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
          end else begin
            state_next.cnt = setup_len;
            state_next.mst = M_SETUP;
          end
        end
        M_SETUP: begin
          if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
          end else begin
            state_next.cnt = state_reg.mde.strobe_wait;
            state_next.mst = M_STROBE;
          end
        end
        M_STROBE: begin
          if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
          end else begin
            // read data are caught on the last strobe cycle
            if (state_reg.is_read) begin
              state_next.rx_data = port_data_pins_in;
            end
            state_next.cnt = {1'b0, hold_len} - 4'h1;
            state_next.mst = (hold_len == 3'h0) ? M_IDLE : M_HOLD;
          end
        end
        M_HOLD: begin
          if (state_reg.cnt != 4'h0) begin
            state_next.cnt = state_reg.cnt - 4'h1;
          end else begin
            state_next.mst = M_IDLE;
          end
        end
        default: state_next.mst = M_IDLE;
      endcase

      // end of a master cycle: clear busy, step address, interrupt
      if ((state_reg.mst == M_STROBE && state_reg.cnt == 4'h0 && hold_len == 3'h0) ||
          (state_reg.mst == M_HOLD && state_reg.cnt == 4'h0)) begin
        state_next.mde.busy = 1'b0;
        state_next.irq      = state_reg.mde.irq_mode == IRQ_CYCLE;
        unique case (state_reg.mde.addr_step_mode)
          STEP_INC: step_val = step_val + 12'h004;
          STEP_DEC: step_val = step_val - 12'h004;
          default: ;
        endcase
        // step counts from bit 2 up; bits 1:0 stay as written
        state_next.addr_lo = {step_val[10:2], state_reg.addr_lo[1:0]};
        if (!cs_as_sel) begin
          state_next.addr_hi14 = step_val[11];
        end
      end
    end else if (!is_master) begin
      state_next.mst      = M_IDLE;
      state_next.mde.busy = 1'b0;
    end

    // slave: the trailing edge of a host strobe completes an access
    if (run && !is_master) begin
      state_next.prev_rd  = h_rd;
      state_next.prev_wr  = h_wr;
      state_next.prev_idx = s_idx;
      if (state_reg.prev_wr && !h_wr) begin
        state_next.in_buf[state_reg.prev_idx*8 +: 8] = port_data_pins_in;
        state_next.in_full[state_reg.prev_idx]       = 1'b1;
      end
      if (state_reg.prev_rd && !h_rd) begin
        state_next.out_empty[state_reg.prev_idx] = 1'b1;
      end
      if ((state_reg.prev_wr && !h_wr) || (state_reg.prev_rd && !h_rd)) begin
        if (state_reg.mde.port_mode_sel == MODE_LEGACY &&
            state_reg.mde.addr_step_mode == STEP_BUF) begin
          state_next.buf_ptr = state_reg.buf_ptr + 2'h1;
        end
        unique case (state_reg.mde.irq_mode)
          IRQ_CYCLE: state_next.irq = 1'b1;
          IRQ_BUF3:  state_next.irq = state_reg.prev_idx == BUF_LAST;
          default: ;
        endcase
      end
    end else begin
      state_next.prev_rd = 1'b0;
      state_next.prev_wr = 1'b0;
    end

    // pin drivers follow the next phase so they line up with it
    lat_lo    = state_next.mst == M_ADDR_LO;
    lat_hi    = state_next.mst == M_ADDR_HI;
    strobe_on = state_next.mst == M_STROBE;

    // data pins: address bytes, write data, or slave read data
    state_next.d_oe  = 1'b0;
    state_next.d_out = state_next.tx_data; // a byte written now is already there for setup
    if (!state_reg.ctl.enable) begin
      state_next.d_oe = 1'b0;
    end else if (is_master) begin
      if (lat_lo) begin
        state_next.d_out = state_next.addr_lo[7:0];
        state_next.d_oe  = 1'b1;
      end else if (lat_hi) begin
        state_next.d_out = {1'b0, state_next.addr_hi14, 3'h0, state_next.addr_lo[10:8]};
        state_next.d_oe  = 1'b1;
      end else begin
        state_next.d_oe = (state_next.mst != M_IDLE) & ~state_next.is_read;
      end
    end else begin
      state_next.d_out = state_reg.out_buf[s_idx*8 +: 8];
      state_next.d_oe  = h_rd;
    end

    // address pins; in mux modes bits 1:0 carry the latch strobes
    state_next.a_oe = state_reg.ctl.enable & is_master;
    unique case (state_reg.ctl.addr_data_mux_sel)
      MUX_NONE:   state_next.a_out = state_next.addr_lo;
      MUX_LOW_UP: state_next.a_out = {state_next.addr_lo[10:8], 8'h00};
      default:    state_next.a_out = 11'h000;
    endcase
    if (state_reg.ctl.addr_data_mux_sel != MUX_NONE) begin
      // latch polarity only touches pins acting as latch strobes
      state_next.a_out[0] = lat_lo ~^ state_reg.ctl.addr_latch_polarity;
      state_next.a_out[1] = lat_hi ~^ state_reg.ctl.addr_latch_polarity;
    end

    // chip-select pin: a select with polarity, or plain address bit 14
    state_next.cs_oe = state_reg.ctl.enable & is_master;
    if (cs_as_sel) begin
      state_next.cs_out = (state_next.addr_hi14 & (state_next.mst != M_IDLE))
                          ~^ state_reg.ctl.chip_select_polarity;
    end else begin
      state_next.cs_out = state_next.addr_hi14;
    end

    // strobes: mode 1 has read/write plus enable, mode 2 separate strobes
    state_next.rd_oe = state_reg.ctl.enable & is_master
                       & state_reg.ctl.rd_strobe_pin_en;
    state_next.wr_oe = state_reg.ctl.enable & is_master
                       & state_reg.ctl.wr_strobe_pin_en;
    if (state_reg.mde.port_mode_sel == MODE_M1) begin
      // read/write pin shows the direction for the whole transfer
      state_next.rd_out = ((state_next.mst != M_IDLE) & state_next.is_read)
                          ~^ state_reg.ctl.read_strobe_polarity;
      state_next.wr_out = strobe_on ~^ state_reg.ctl.write_strobe_polarity;
    end else begin
      state_next.rd_out = (strobe_on & state_next.is_read)
                          ~^ state_reg.ctl.read_strobe_polarity;
      state_next.wr_out = (strobe_on & ~state_next.is_read)
                          ~^ state_reg.ctl.write_strobe_polarity;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata            = state_reg.rdata;
  assign port_irq             = state_reg.irq;
  assign port_data_pins_out   = state_reg.d_out;
  assign port_data_pins_oe    = state_reg.d_oe;
  assign port_addr_pins_out   = state_reg.a_out;
  assign port_addr_pins_oe    = state_reg.a_oe;
  assign chip_select_pin_out  = state_reg.cs_out;
  assign chip_select_pin_oe   = state_reg.cs_oe;
  assign read_strobe_pin_out  = state_reg.rd_out;
  assign read_strobe_pin_oe   = state_reg.rd_oe;
  assign write_strobe_pin_out = state_reg.wr_out;
  assign write_strobe_pin_oe  = state_reg.wr_oe;

endmodule : pmsp_port

`default_nettype wire

// ==== verification/pmsp_chk.sv ====
/* assertions on the port pins, fed by shadows of control and mode.
   assumes transfers start only while idle, with address bit 14 set */
`timescale 1ns/1ps
`default_nettype none
module pmsp_chk
  import pmsp_pkg::*;
(
  // clock, reset, register writes
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // system state and pins
  input wire logic        sys_idle,
  input wire logic        port_irq,
  input wire logic        port_data_pins_oe,
  input wire logic        chip_select_pin_out,
  input wire logic        read_strobe_pin_out,
  input wire logic        read_strobe_pin_oe,
  input wire logic        write_strobe_pin_out,
  input wire logic        write_strobe_pin_oe
);
  pmsp_control_s ctl_reg;  // control shadow
  pmsp_mode_s    mode_reg; // mode shadow
  logic [31:0]   last_q;   // both shadows one cycle ago
  logic [4:0]    cnt_reg;  // length of the current strobe
  logic          stb, m2, wr_act, act;
  // pins lag a register write, so only settled settings are judged
  assign stb    = last_q == {ctl_reg, mode_reg};
  assign m2     = stb && mode_reg.port_mode_sel == MODE_M2;
  assign wr_act = m2 && write_strobe_pin_oe && write_strobe_pin_out == ctl_reg[1];
  assign act    = wr_act || (m2 && read_strobe_pin_oe && read_strobe_pin_out == ctl_reg[0]);
  // shadows follow bus writes; a counter, since strobes run up to 16 cycles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {ctl_reg, mode_reg, last_q, cnt_reg} <= '0;
    end else begin
      if (reg_wr && reg_addr == OFS_CONTROL) ctl_reg <= reg_wdata[15:0];
      if (reg_wr && reg_addr == OFS_MODE) mode_reg <= reg_wdata[15:0];
      last_q <= {ctl_reg, mode_reg};
      cnt_reg <= act ? cnt_reg + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_OFF: assert property (stb && !ctl_reg.enable |-> !port_data_pins_oe)
    else $error("data driven while off");
  AST_WR_PIN: assert property (stb && !ctl_reg[9] |-> !write_strobe_pin_oe)
    else $error("write pin driven");
  AST_RD_PIN: assert property (stb && !ctl_reg[8] |-> !read_strobe_pin_oe)
    else $error("read pin driven");
  AST_WALK: assert property (reg_wr && reg_addr == OFS_DATA && m2 && !sys_idle
    && ctl_reg.enable && ctl_reg.addr_data_mux_sel == MUX_NONE && mode_reg.strobe_wait == 4'h0
    && mode_reg.irq_mode == IRQ_CYCLE && ctl_reg[9] |-> ##2 wr_act ##1 !wr_act ##1 port_irq)
    else $error("short write out of step");
  AST_LEN: assert property (!act && cnt_reg != 5'h00
    |-> cnt_reg == {1'b0, mode_reg.strobe_wait} + 5'h01) else $error("strobe length");
  AST_CS: assert property (act && ctl_reg[7:6] == CS_FUNC_SEL
    |-> chip_select_pin_out == ctl_reg[3]) else $error("select level");
  AST_DATA: assert property (wr_act |-> port_data_pins_oe)
    else $error("data not driven in strobe");
  AST_NOIRQ: assert property (stb && mode_reg.irq_mode == 2'h0 |-> !port_irq)
    else $error("interrupt in mode 00");
endmodule : pmsp_chk
bind pmsp_port pmsp_chk u_chk (.*);
`default_nettype wire

// ==== verification/pmsp_dev.sv ====
/* byte device on the far side of the port in master mode 2.
   assumes the bench decodes the strobe pins to active levels */
`timescale 1ns/1ps
`default_nettype none
module pmsp_dev (
  // strobes, already decoded
  input  wire logic       clk_sys,
  input  wire logic       rd_act,
  input  wire logic       wr_act,
  // data
  input  wire logic [7:0] d_in,   // port data pins
  input  wire logic [7:0] rd_val, // byte returned on reads
  output var  logic [7:0] got,    // last byte written
  output var  logic [7:0] d_out   // drive toward the port
);
  logic flip = 1'b0; // a released bus keeps no value
  // latch written bytes while the write strobe is active
  always_ff @(posedge clk_sys) begin
    flip <= ~flip;
    if (wr_act) got <= d_in;
  end
  assign d_out = rd_act ? rd_val : {8{flip}} ^ got;
endmodule : pmsp_dev
`default_nettype wire

// ==== verification/testbench.sv ====
/* bench for the port: mode 2 transfers against a byte device, reset values,
   idle stop and disable. assumes the checker is bound to the port */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pmsp_pkg::*;
;
  logic        clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sys_idle = 1'b0;
  logic [7:0]  reg_addr = 8'h00, rd_val = 8'h00, port_data_pins_in, port_data_pins_out, dev_d, got;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q, a, seed = 32'h57;
  logic [10:0] port_addr_pins_out;
  logic [1:0]  port_addr_pins_in = 2'h0; // slave inputs parked inactive
  logic        chip_select_pin_in = 1'b1, read_strobe_pin_in = 1'b1, write_strobe_pin_in = 1'b1;
  logic        port_irq, port_data_pins_oe, port_addr_pins_oe, chip_select_pin_out;
  logic        chip_select_pin_oe, read_strobe_pin_out, read_strobe_pin_oe;
  logic        write_strobe_pin_out, write_strobe_pin_oe;
  int          miscompares = 0, n_tests = 0;
  pmsp_control_s c = '0; // control as last written
  pmsp_mode_s    m;      // mode as last written
  pmsp_port uut (.*);
  pmsp_dev u_dev (.clk_sys(clk_sys), .d_in(port_data_pins_out), .rd_val(rd_val), .got(got),
    .d_out(dev_d), .rd_act(read_strobe_pin_oe && read_strobe_pin_out === c[0]),
    .wr_act(write_strobe_pin_oe && write_strobe_pin_out === c[1]));
  assign port_data_pins_in = port_data_pins_oe ? port_data_pins_out : dev_d;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // address after one step; bit 14 is a select here, so never carried into
  function automatic logic [31:0] nxt(input logic [31:0] v, input logic up);
    logic [8:0] f;
    f = up ? v[10:2] + 9'h001 : v[10:2] - 9'h001;
    return {v[31:11], f, v[1:0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // a gap cycle after each write keeps the strobe from being set twice at one edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    q = reg_rdata; // the word still stands at the edge that closes its cycle
  endtask : rd
  task automatic wirq(input int n, input logic e);
    logic hit;
    hit = 1'b0;
    repeat (n) if (!hit) begin
      @(posedge clk_sys);
      #1 hit = port_irq === 1'b1;
    end
    chk("irq", {31'h0, e}, {31'h0, hit});
    if (e && !hit) summarize();
  endtask : wirq
  initial forever #20 clk_sys = ~clk_sys;
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(OFS_CONTROL);
    chk("control reset", {16'h0, RESET_16}, q);
    rd(8'hFC);
    chk("unmapped", 32'h0, q);
    // pass 0: zero waits, low polarity, wrap; pass 1: random waits, high polarity
    for (int p = 0; p < 2; p++) begin
      seed = xs(seed);
      c = p ? 16'h838B : 16'h8380;
      m = {1'b0, IRQ_CYCLE, p ? STEP_DEC : STEP_INC, 1'b0, MODE_M2, p ? seed[7:0] | 8'h44 : 8'h00};
      a = p ? {17'h0, 1'b1, 3'h0, seed[18:8]} : 32'h47FC;
      wr(OFS_CONTROL, {16'h0, c});
      wr(OFS_MODE, {16'h0, m});
      wr(OFS_ADDR, a);
      wr(OFS_DATA, {24'h0, seed[31:24]});
      wirq(80, 1'b1);
      chk("device byte", {24'h0, seed[31:24]}, {24'h0, got});
      rd(OFS_ADDR);
      chk("address", nxt(a, p == 0), q);
      rd_val = seed[23:16];
      rd(OFS_DATA);
      if (p) rd(OFS_MODE);
      if (p) chk("busy", 32'h1, {31'h0, q[15]});
      wirq(80, 1'b1);
      rd(OFS_DATA);
      chk("read byte", {24'h0, rd_val}, q);
      wirq(80, 1'b1);
      rd(OFS_MODE);
      chk("idle busy", 32'h0, {31'h0, q[15]});
    end
    c = 16'hA380;
    wr(OFS_CONTROL, {16'h0, c});
    wr(OFS_MODE, {17'h0, IRQ_CYCLE, STEP_INC, 1'b0, MODE_M2, 8'hFF});
    wr(OFS_DATA, 32'hA5);
    sys_idle <= 1'b1;
    wirq(30, 1'b0);
    sys_idle <= 1'b0;
    wirq(60, 1'b1);
    c = 16'h0380;
    wr(OFS_CONTROL, {16'h0, c});
    wr(OFS_DATA, 32'h3C);
    wirq(30, 1'b0);
    chk("data drive", 32'h0, {31'h0, port_data_pins_oe});
    // enhanced slave: the host reads buffer 3 by address, low-active strobes
    wr(OFS_CONTROL, 32'h8000);
    wr(OFS_MODE, {17'h0, IRQ_BUF3, 2'h0, 1'b0, MODE_ENH, 8'h00});
    wr(OFS_SLV_OUT, seed);
    port_addr_pins_in <= BUF_LAST;
    chip_select_pin_in <= 1'b0;
    read_strobe_pin_in <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("slave byte", {24'h0, seed[31:24]}, {24'h0, port_data_pins_out});
    read_strobe_pin_in <= 1'b1;
    wirq(4, 1'b1);
    rd(OFS_SLV_ST);
    chk("slave flags", 32'h8, q);
    summarize();
  end
endmodule : testbench
`default_nettype wire
